// file: rtl/trace_pkg.sv
`default_nettype none
package trace_pkg;
    localparam int POINTS = 1001;
    localparam int VECTORS = 1000;
    localparam int ADDR_W = 10;
    localparam int AMP_W = 10;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3E8;
    localparam logic [ADDR_W-1:0] MID_ADDR = 10'h1F4;
    // Frequencies in units of 0.1 Hz; 40.1 MHz is 401,000,000 units.
    localparam int FREQ_W = 29;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 29'h17E6_C640;
    localparam int CLK_MHZ = 250;
    localparam int REFRESH_MS = 17;
    localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ;
    localparam int MSG_S = 5;
    localparam longint MSG_CYC_L = longint'(MSG_S) * 1000000 * CLK_MHZ;
    localparam int MSG_CYC = int'(MSG_CYC_L);
    localparam int CNT_W = 32;
    localparam logic [AMP_W-1:0] UNITS_PER_DIV = 10'h064;
    localparam logic [AMP_W-1:0] TOP_LINE = 10'h3E8;
    localparam logic [AMP_W-1:0] OVER_UNITS = 10'h017;
    localparam logic [1:0] SCALE_10DB = 2'h0;
    localparam logic [1:0] SCALE_5DB = 2'h1;
    localparam logic [1:0] SCALE_2DB = 2'h2;
    localparam logic [1:0] SCALE_1DB = 2'h3;
    localparam logic [7:0] RANGE_10DB = 8'h64;
    localparam logic [7:0] RANGE_5DB = 8'h32;
    localparam logic [7:0] RANGE_2DB = 8'h14;
    localparam logic [7:0] RANGE_1DB = 8'h0A;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_START = 8'h04;
    localparam logic [7:0] ADR_STOP = 8'h08;
    localparam logic [7:0] ADR_CENTER = 8'h0C;
    localparam logic [7:0] ADR_SPAN = 8'h10;
    localparam logic [7:0] ADR_RATE = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_IRQ_ST = 8'h1C;
    localparam logic [7:0] ADR_IRQ_MSK = 8'h20;
    localparam logic [7:0] ADR_MARKER = 8'h24;
    localparam logic [7:0] ADR_STEP = 8'h28;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SINGLE = 1;
    localparam int CTRL_SCALE = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_LIMIT = 1;
    localparam int IRQ_FRAME = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [1:0]
    {
        WR_IDLE = 2'b00,
        WR_SWEEP = 2'b01,
        WR_HELD = 2'b10
    } wr_state_e;
    typedef struct packed
    {
        logic valid;
        logic [ADDR_W-1:0] index;
        logic [AMP_W-1:0] y0;
        logic [AMP_W-1:0] y1;
        logic blank;
    } vector_s;
endpackage : trace_pkg
`default_nettype wire

// file: rtl/trace_storage_display_scan.sv
// The implementer's own choices: register access over Wishbone and the register addresses.
`default_nettype none
module trace_storage_display_scan #(
    parameter int REFRESH_CYCLES = trace_pkg::REFRESH_CYC,
    parameter int MSG_CYCLES = trace_pkg::MSG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sample_valid_i,
    input wire logic [trace_pkg::AMP_W-1:0] sample_i,
    output trace_pkg::vector_s vector_o,
    output logic frame_start_o,
    output logic [7:0] display_range_o,
    output logic span_limited_o,
    output logic irq_o
);
    localparam int AW = trace_pkg::ADDR_W;
    localparam int DW = trace_pkg::AMP_W;
    localparam int FW = trace_pkg::FREQ_W;
    localparam int IRQ_W_L = trace_pkg::IRQ_W;
    localparam int CNT_W_L = trace_pkg::CNT_W;

    // ============================================================
    // Register bus
    logic [DW-1:0] mem [0:trace_pkg::POINTS-1];
    logic [31:0] ctrl_reg;
    logic [FW-1:0] start_reg, stop_reg, center_reg, span_reg;
    logic [31:0] rate_reg;
    logic [IRQ_W_L-1:0] irq_st_reg, irq_msk_reg;
    logic [AW-1:0] marker_reg;
    logic [FW-1:0] step_reg;
    logic [IRQ_W_L-1:0] ev;
    logic msg_reg;
    logic [AW-1:0] mark_amp_reg;
    logic wr_req;
    logic [FW:0] lo_calc, hi_calc;
    logic [FW-1:0] center_set, span_set;
    logic [7:0] a;

    assign a = wb_adr_i[7:0];
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (&wb_sel_i);

    function automatic logic [FW-1:0] clip_freq(input logic [31:0] v);
        clip_freq = (v > 32'(trace_pkg::FREQ_MAX)) ? trace_pkg::FREQ_MAX : v[FW-1:0];
    endfunction : clip_freq

    // Centre/span form the requested range; it is clamped on the recompute_reg cycle.
    always_comb
    begin
        center_set = clip_freq(wb_dat_i);
        span_set = clip_freq(wb_dat_i);
        lo_calc = {1'b0, center_reg} - {2'b00, span_reg[FW-1:1]};
        hi_calc = {1'b0, center_reg} + {2'b00, span_reg[FW-1:1]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    logic recompute_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= 32'h0000_0000;
            start_reg <= '0;
            stop_reg <= trace_pkg::FREQ_MAX;
            center_reg <= trace_pkg::FREQ_MAX >> 1;
            span_reg <= trace_pkg::FREQ_MAX;
            rate_reg <= 32'h0000_0001;
            irq_msk_reg <= '0;
            marker_reg <= '0;
            recompute_reg <= 1'b0;
        end
        else
        begin
            recompute_reg <= 1'b0;
            if (wr_req)
            begin
                if (a == trace_pkg::ADR_CTRL)
                begin
                    ctrl_reg <= wb_dat_i;
                end
                else if (a == trace_pkg::ADR_START)
                begin
                    start_reg <= clip_freq(wb_dat_i);
                    span_reg <= (stop_reg > clip_freq(wb_dat_i)) ?
                        stop_reg - clip_freq(wb_dat_i) : '0;
                    center_reg <= FW'(({1'b0, clip_freq(wb_dat_i)} + {1'b0, stop_reg}) >> 1);
                end
                else if (a == trace_pkg::ADR_STOP)
                begin
                    stop_reg <= clip_freq(wb_dat_i);
                    span_reg <= (clip_freq(wb_dat_i) > start_reg) ?
                        clip_freq(wb_dat_i) - start_reg : '0;
                    center_reg <= FW'(({1'b0, clip_freq(wb_dat_i)} + {1'b0, start_reg}) >> 1);
                end
                else if (a == trace_pkg::ADR_CENTER)
                begin
                    center_reg <= center_set;
                    recompute_reg <= 1'b1;
                end
                else if (a == trace_pkg::ADR_SPAN)
                begin
                    span_reg <= span_set;
                    recompute_reg <= 1'b1;
                end
                else if (a == trace_pkg::ADR_RATE)
                begin
                    rate_reg <= (wb_dat_i == 32'h0) ? 32'h0000_0001 : wb_dat_i;
                end
                else if (a == trace_pkg::ADR_IRQ_MSK)
                begin
                    irq_msk_reg <= wb_dat_i[IRQ_W_L-1:0];
                end
                else if (a == trace_pkg::ADR_MARKER)
                begin
                    // Whole points only; beyond the last point sticks at stop.
                    marker_reg <= (wb_dat_i[AW-1:0] > trace_pkg::LAST_ADDR) ?
                        trace_pkg::LAST_ADDR : wb_dat_i[AW-1:0];
                end
            end
            if (recompute_reg)
            begin
                // Clamp the swept range to 0 .. 40.1 MHz.
                start_reg <= lo_calc[FW] ? '0 : lo_calc[FW-1:0];
                stop_reg <= (hi_calc > {1'b0, trace_pkg::FREQ_MAX}) ?
                    trace_pkg::FREQ_MAX : hi_calc[FW-1:0];
            end
        end
    end

    // Requested (unclamped) range, in 0.1 Hz units, for blanking.
    logic [FW:0] req_lo_reg, req_hi_reg;
    logic lim_evt;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_lo_reg <= '0;
            req_hi_reg <= '0;
            lim_evt <= 1'b0;
        end
        else
        begin
            lim_evt <= recompute_reg && (lo_calc[FW] ||
                hi_calc > {1'b0, trace_pkg::FREQ_MAX});
            if (recompute_reg)
            begin
                req_lo_reg <= lo_calc;
                req_hi_reg <= hi_calc;
            end
        end
    end

    // Point spacing, span / 1000, by repeated subtraction.
    logic [FW-1:0] div_rem, div_q;
    logic div_busy;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_rem <= '0;
            div_q <= '0;
            div_busy <= 1'b0;
            step_reg <= '0;
        end
        else if (recompute_reg || (wr_req && (a == trace_pkg::ADR_START ||
            a == trace_pkg::ADR_STOP || a == trace_pkg::ADR_SPAN)))
        begin
            div_busy <= 1'b0;
            div_q <= '0;
        end
        else if (!div_busy)
        begin
            div_rem <= span_reg;
            div_q <= '0;
            div_busy <= 1'b1;
        end
        else if (div_rem >= FW'(trace_pkg::VECTORS))
        begin
            div_rem <= div_rem - FW'(trace_pkg::VECTORS);
            div_q <= div_q + 1'b1;
        end
        else
        begin
            step_reg <= div_q;
        end
    end

    // ============================================================
    // Sweep write side
    logic [31:0] rate_cnt;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] peak_reg;
    logic peak_any;
    logic done_evt;
    logic [AW-1:0] blank_lo, blank_hi;
    logic erase_busy;
    logic [AW-1:0] erase_addr;

    logic held_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rate_cnt <= '0;
            wr_addr <= '0;
            peak_reg <= '0;
            peak_any <= 1'b0;
            done_evt <= 1'b0;
            held_reg <= 1'b0;
        end
        else
        begin
            done_evt <= 1'b0;
            if (!ctrl_reg[trace_pkg::CTRL_RUN] || held_reg)
            begin
                rate_cnt <= '0;
                wr_addr <= '0;
                peak_any <= 1'b0;
                if (!ctrl_reg[trace_pkg::CTRL_RUN])
                begin
                    held_reg <= 1'b0;
                end
            end
            else
            begin
                // Peak detect between point strobes.
                if (sample_valid_i && (!peak_any || sample_i > peak_reg))
                begin
                    peak_reg <= sample_i;
                    peak_any <= 1'b1;
                end
                if (rate_cnt + 32'h1 >= rate_reg)
                begin
                    rate_cnt <= '0;
                    peak_any <= 1'b0;
                    wr_addr <= (wr_addr == trace_pkg::LAST_ADDR) ? '0 : wr_addr + 1'b1;
                    if (wr_addr == trace_pkg::LAST_ADDR)
                    begin
                        done_evt <= 1'b1;
                        held_reg <= ctrl_reg[trace_pkg::CTRL_SINGLE];
                    end
                end
                else
                begin
                    rate_cnt <= rate_cnt + 32'h1;
                end
            end
        end
    end

    // Blanked points: those of the requested range outside 0 .. 40.1 MHz.
    always_comb
    begin
        blank_lo = '0;
        blank_hi = trace_pkg::LAST_ADDR;
        if (req_lo_reg[FW] && step_reg != '0)
        begin
            blank_lo = AW'((~req_lo_reg + 1'b1) / {1'b0, step_reg});
        end
        if (req_hi_reg > {1'b0, trace_pkg::FREQ_MAX} && step_reg != '0)
        begin
            blank_hi = trace_pkg::LAST_ADDR -
                AW'((req_hi_reg - {1'b0, trace_pkg::FREQ_MAX}) / {1'b0, step_reg});
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            erase_busy <= 1'b0;
            erase_addr <= '0;
        end
        else if (lim_evt && held_reg)
        begin
            erase_busy <= 1'b1;
            erase_addr <= '0;
        end
        else if (erase_busy)
        begin
            erase_addr <= erase_addr + 1'b1;
            erase_busy <= (erase_addr != trace_pkg::LAST_ADDR);
        end
    end

    logic pt_strobe;
    assign pt_strobe = ctrl_reg[trace_pkg::CTRL_RUN] && !held_reg &&
        (rate_cnt + 32'h1 >= rate_reg);

    always_ff @(posedge clk_i)
    begin
        if (erase_busy && (erase_addr < blank_lo || erase_addr > blank_hi))
        begin
            mem[erase_addr] <= '0;
        end
        else if (pt_strobe)
        begin
            // Include this cycle's sample in the point's peak.
            mem[wr_addr] <= (sample_valid_i && (!peak_any || sample_i > peak_reg)) ?
                sample_i : (peak_any ? peak_reg : '0);
        end
    end

    // ============================================================
    // Display scan side
    logic [CNT_W_L-1:0] frame_cnt;
    logic [AW-1:0] rd_addr;
    logic scanning;
    logic [DW-1:0] rd_data, prev_data;
    logic rd_valid;
    logic [AW-1:0] rd_idx;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frame_cnt <= '0;
            frame_start_o <= 1'b0;
        end
        else
        begin
            // Free-running period: no setting reaches this counter.
            frame_start_o <= (frame_cnt == CNT_W_L'(REFRESH_CYCLES - 1));
            frame_cnt <= (frame_cnt == CNT_W_L'(REFRESH_CYCLES - 1)) ? '0 : frame_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_addr <= '0;
            scanning <= 1'b0;
            rd_valid <= 1'b0;
            rd_idx <= '0;
        end
        else
        begin
            rd_valid <= scanning;
            rd_idx <= rd_addr;
            if (frame_start_o)
            begin
                scanning <= 1'b1;
                rd_addr <= '0;
            end
            else if (scanning)
            begin
                rd_addr <= rd_addr + 1'b1;
                scanning <= (rd_addr != trace_pkg::LAST_ADDR);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        rd_data <= mem[rd_addr];
        mark_amp_reg <= mem[marker_reg];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_data <= '0;
            vector_o <= '0;
        end
        else
        begin
            vector_o.valid <= 1'b0;
            if (rd_valid)
            begin
                prev_data <= rd_data;
                // One vector per adjacent pair, none for point 0.
                vector_o.valid <= (rd_idx != '0);
                vector_o.index <= rd_idx;
                vector_o.y0 <= prev_data;
                vector_o.y1 <= rd_data;
                vector_o.blank <= (rd_idx <= blank_lo && blank_lo != '0) ||
                    (rd_idx > blank_hi);
            end
        end
    end

    // ============================================================
    // Scale, indication and interrupts
    logic [CNT_W_L-1:0] msg_cnt;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            msg_reg <= 1'b0;
            msg_cnt <= '0;
            span_limited_o <= 1'b0;
        end
        else
        begin
            if (lim_evt)
            begin
                msg_reg <= 1'b1;
                msg_cnt <= '0;
            end
            else if (msg_reg)
            begin
                msg_cnt <= msg_cnt + 1'b1;
                msg_reg <= (msg_cnt != CNT_W_L'(MSG_CYCLES - 1));
            end
            span_limited_o <= msg_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            display_range_o <= trace_pkg::RANGE_10DB;
        end
        else
        begin
            case (ctrl_reg[trace_pkg::CTRL_SCALE +: 2])
                trace_pkg::SCALE_10DB: display_range_o <= trace_pkg::RANGE_10DB;
                trace_pkg::SCALE_5DB: display_range_o <= trace_pkg::RANGE_5DB;
                trace_pkg::SCALE_2DB: display_range_o <= trace_pkg::RANGE_2DB;
                default: display_range_o <= trace_pkg::RANGE_1DB;
            endcase
        end
    end

    assign ev = {frame_start_o, lim_evt, done_evt};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_st_reg <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            // A new event wins over a same-cycle clear.
            if (wr_req && a == trace_pkg::ADR_IRQ_ST)
            begin
                irq_st_reg <= (irq_st_reg & ~wb_dat_i[IRQ_W_L-1:0]) | ev;
            end
            else
            begin
                irq_st_reg <= irq_st_reg | ev;
            end
            irq_o <= |(irq_st_reg & irq_msk_reg);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= '0;
        end
        else if (a == trace_pkg::ADR_CTRL)
        begin
            wb_dat_o <= ctrl_reg;
        end
        else if (a == trace_pkg::ADR_START)
        begin
            wb_dat_o <= 32'(start_reg);
        end
        else if (a == trace_pkg::ADR_STOP)
        begin
            wb_dat_o <= 32'(stop_reg);
        end
        else if (a == trace_pkg::ADR_CENTER)
        begin
            wb_dat_o <= 32'(center_reg);
        end
        else if (a == trace_pkg::ADR_SPAN)
        begin
            wb_dat_o <= 32'(span_reg);
        end
        else if (a == trace_pkg::ADR_RATE)
        begin
            wb_dat_o <= rate_reg;
        end
        else if (a == trace_pkg::ADR_STATUS)
        begin
            // Bit 12 tells software that the marker point lies in the overrange band.
            wb_dat_o <= {19'h0, mark_amp_reg > trace_pkg::TOP_LINE, held_reg, msg_reg,
                wr_addr};
        end
        else if (a == trace_pkg::ADR_IRQ_ST)
        begin
            wb_dat_o <= 32'(irq_st_reg);
        end
        else if (a == trace_pkg::ADR_IRQ_MSK)
        begin
            wb_dat_o <= 32'(irq_msk_reg);
        end
        else if (a == trace_pkg::ADR_MARKER)
        begin
            wb_dat_o <= {6'h0, mark_amp_reg, 6'h0, marker_reg};
        end
        else if (a == trace_pkg::ADR_STEP)
        begin
            wb_dat_o <= 32'(step_reg);
        end
        else
        begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ============================================================
    // Checks
    property p_vec_count;
        @(posedge clk_i) disable iff (rst_i)
        $rose(frame_start_o) |-> ##3 vector_o.valid == 1'b0;
    endproperty
    a_vec_count: assert property (p_vec_count) else $error("vector for point 0");

    property p_frame_period;
        @(posedge clk_i) disable iff (rst_i)
        frame_start_o |=> !frame_start_o;
    endproperty
    a_frame_period: assert property (p_frame_period) else $error("frame pulse too long");

    property p_scan_len;
        @(posedge clk_i) disable iff (rst_i)
        frame_start_o |=> scanning;
    endproperty
    a_scan_len: assert property (p_scan_len) else $error("scan did not start");

    property p_marker;
        @(posedge clk_i) disable iff (rst_i)
        marker_reg <= trace_pkg::LAST_ADDR;
    endproperty
    a_marker: assert property (p_marker) else $error("marker off trace");

    property p_wr_addr;
        @(posedge clk_i) disable iff (rst_i)
        wr_addr <= trace_pkg::LAST_ADDR;
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address past store");

    property p_limit_flag;
        @(posedge clk_i) disable iff (rst_i)
        lim_evt |=> ##1 span_limited_o;
    endproperty
    a_limit_flag: assert property (p_limit_flag) else $error("limit not shown");

    property p_freq_max;
        @(posedge clk_i) disable iff (rst_i)
        stop_reg <= trace_pkg::FREQ_MAX && start_reg <= trace_pkg::FREQ_MAX;
    endproperty
    a_freq_max: assert property (p_freq_max) else $error("frequency beyond limit");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        |(irq_st_reg & irq_msk_reg) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : trace_storage_display_scan
`default_nettype wire

// file: dv/video_source.sv
`default_nettype none
// ==========
// Front end model.
// It alternates full and half level, so the peak of any segment of two or more samples is the full level.
module video_source (
    input wire logic clk_i,
    input wire logic [9:0] level_i,
    output logic sample_valid_o,
    output logic [9:0] sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic half_reg = 1'b0;
    always_ff @(posedge clk_i)
    begin
        half_reg <= !half_reg;
        sample_valid_o <= 1'b1;
        sample_o <= half_reg ? level_i >> 1 : level_i;
    end
endmodule : video_source
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 2000;
    localparam int MC = 100;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, sv, ack, fs, lim, irq;
    logic [9:0] smp;
    logic [9:0] amp = 10'h000;
    logic [7:0] rng;
    trace_pkg::vector_s vec;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    always #2 clk_i = !clk_i;
    video_source video_source_i (.clk_i(clk_i), .level_i(amp), .sample_valid_o(sv),
        .sample_o(smp));
    trace_storage_display_scan #(.REFRESH_CYCLES(RC), .MSG_CYCLES(MC))
        trace_storage_display_scan_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sample_valid_i(sv), .sample_i(smp),
        .vector_o(vec), .frame_start_o(fs), .display_range_o(rng),
        .span_limited_o(lim), .irq_o(irq));
    // ==========
    // Helpers.
    function automatic logic [7:0] exp_range(input logic [1:0] s);
        case (s)
            2'h0: return 8'h64;
            2'h1: return 8'h32;
            2'h2: return 8'h14;
            default: return 8'h0A;
        endcase
    endfunction : exp_range
    // Points left of 0 Hz are erased once the span is limited on a held trace.
    function automatic logic [9:0] exp_amp(input int k, input int lo);
        return (k < lo) ? 10'h000 : amp;
    endfunction : exp_amp
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= {24'h0, a};
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic scan_frame(input int lo);
        logic [31:0] e;
        n = 0;
        do tick(1); while (fs !== 1'b1);
        for (int i = 1; i <= RC; i++)
        begin
            tick(1);
            if (vec.valid === 1'b1)
            begin
                n++;
                e = {n <= lo, n[9:0], exp_amp(n - 1, lo), exp_amp(n, lo)};
                chk({vec.blank, vec.index, vec.y0, vec.y1}, e);
            end
            if (fs === 1'b1)
            begin
                chk(i, RC);
                break;
            end
        end
        chk(n, 1000);
    endtask : scan_frame
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // ==========
    // Tests.
    initial
    begin
        void'($urandom(23));
        tick(2);
        rst_i <= 1'b0;
        chk(rng, 8'h64);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            wb(1'b1, trace_pkg::ADR_CTRL, {28'h0, s[1:0], 2'b00});
            tick(2);
            chk(rng, exp_range(s[1:0]));
        end
        wb(1'b1, trace_pkg::ADR_START, 32'h0);
        wb(1'b1, trace_pkg::ADR_STOP, 32'h0000_2710);
        tick(8000);
        wb(1'b0, trace_pkg::ADR_STEP, 32'h0);
        chk(q, 32'd10000 / 1000);
        amp <= 10'($urandom_range(1023, 1));
        // Two samples per point, so each segment holds one full-level sample.
        wb(1'b1, trace_pkg::ADR_RATE, 32'h2);
        wb(1'b1, trace_pkg::ADR_CTRL, 32'h3);
        do wb(1'b0, trace_pkg::ADR_IRQ_ST, 32'h0); while (q[0] !== 1'b1);
        wb(1'b1, trace_pkg::ADR_MARKER, 32'h1F4);
        wb(1'b0, trace_pkg::ADR_MARKER, 32'h0);
        chk(q, {6'h0, amp, 6'h0, 10'h1F4});
        wb(1'b0, trace_pkg::ADR_STATUS, 32'h0);
        chk(q[12:11], {amp > 10'h3E8, 1'b1});
        wb(1'b1, trace_pkg::ADR_IRQ_MSK, 32'h4);
        wb(1'b1, trace_pkg::ADR_IRQ_ST, 32'h7);
        scan_frame(0);
        chk(irq, 1'b1);
        wb(1'b1, trace_pkg::ADR_IRQ_MSK, 32'h0);
        tick(2);
        chk(irq, 1'b0);
        wb(1'b1, trace_pkg::ADR_CENTER, 32'h64);
        wb(1'b1, trace_pkg::ADR_SPAN, 32'h3E8);
        tick(3);
        chk(lim, 1'b1);
        wb(1'b0, trace_pkg::ADR_IRQ_ST, 32'h0);
        chk(q[1], 1'b1);
        tick(MC + 10);
        chk(lim, 1'b0);
        // Span 1000 around 100 puts 400 one-unit points below 0 Hz.
        scan_frame((1000 / 2 - 100) / (1000 / 1000));
        wrap_up();
    end
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
